// [src/phl_ctrl.sv]
// Link-side request controller: queues software requests, sends them as serial
// frames on the request line, collects status transfers, answers bus grants.
// Assumes the interface clock pin is asynchronous to CLK_SYS and at most a
// quarter of its rate; the two-way pins are resolved outside this module.
//
// Contract
// - The phy owns control and data pairs; link drives only after grant.
// - Only requests start from the link; the phy starts status, transmit, receive.
// - Link control codes: 00 release, 01 hold, 10 transmit; never 11.
// - Each request frame starts with bit 1 and ends with bit 0.
// - Frame bits go out in ascending index; bit 0 first and most significant.
// - Frame lengths: bus request 7, register read 9, register write 17.
// - Bus request carries type in bits 1-3 and speed 00 in bits 4-5.
// - Read request: type 100, address bits 4-7, stop bit at 8.
// - Write request: type 101, address 4-7, data 8-15, stop at 16.
// - The link uses the request line for every activity it starts.
// - Type codes: 000 immediate, 001 iso, 010 priority, 011 fair, 100/101 register.
//
// Strobed register access and the register addresses were decided locally.
`default_nettype none
`include "phl_regs.svh"

module phl_ctrl (
    // System clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    // Local register port
    input  wire logic [3:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output var  logic [31:0] RDATA,
    output var  logic        REQ_READY,
    // Phy interface pins
    input  wire logic        IF_CLK,
    output var  logic        LINK_SERVICE_REQUEST_LINE,
    input  wire logic [1:0]  CTL_I,
    output var  logic [1:0]  CTL_O,
    output var  logic        CTL_OE,
    input  wire logic [1:0]  D_I,
    output var  logic [1:0]  D_O,
    output var  logic        D_OE
);
    import phl_pkg::*;

    phl_state_s s_reg;
    phl_state_s s_next;
    logic       rise;
    logic       load;
    logic       cap;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // A synchronised value is accepted only once the second and third stages agree.
    function automatic logic [1:0] phl_filter(input logic [1:0] st2, input logic [1:0] st3,
                                              input logic [1:0] held);
        phl_filter = (st2 == st3) ? st3 : held;
    endfunction

    // Frame length for a request type.
    function automatic logic [4:0] phl_len(input logic [2:0] typ);
        phl_len = (typ == `PHL_TYPE_READ)  ? `PHL_LEN_READ :
                  (typ == `PHL_TYPE_WRITE) ? `PHL_LEN_WRITE : `PHL_LEN_BUS;
    endfunction

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    // All behaviour is here; the clocked process below only registers it.
    always_comb begin
        logic [1:0] clk_new;
        logic [1:0] ctl_new;
        logic [1:0] d_new;
        logic [1:0] slot;
        phl_entry_t head;
        clk_new = 2'h0;
        ctl_new = 2'h0;
        d_new   = 2'h0;
        slot    = 2'h0;
        head    = s_reg.bufm[0];
        cap     = 1'b0;
        s_next  = s_reg;

        // Three-stage synchronisers; stage one feeds only stage two.
        s_next.clk_sync = {s_reg.clk_sync[1:0], IF_CLK};
        s_next.ctl_sync = {s_reg.ctl_sync[3:0], CTL_I};
        s_next.d_sync   = {s_reg.d_sync[3:0], D_I};
        clk_new = phl_filter({1'b0, s_reg.clk_sync[1]}, {1'b0, s_reg.clk_sync[2]},
                             {1'b0, s_reg.clk_acc});
        ctl_new = phl_filter(s_reg.ctl_sync[3:2], s_reg.ctl_sync[5:4], s_reg.ctl_acc);
        d_new   = phl_filter(s_reg.d_sync[3:2], s_reg.d_sync[5:4], s_reg.d_acc);
        s_next.clk_acc = clk_new[0];
        rise = clk_new[0] && !s_reg.clk_acc;
        if (rise) begin
            s_next.ctl_acc = ctl_new;
            s_next.d_acc   = d_new;
        end

        // A frame is loaded when enabled, the line is quiet and a request waits.
        load = s_reg.enable && (s_reg.cnt == 5'h00) && (s_reg.buf_cnt != 2'h0);
        if (load) begin
            s_next.ftype = head[14:12];
            s_next.len   = phl_len(head[14:12]);
            s_next.cnt   = phl_len(head[14:12]);
            unique case (head[14:12])
                `PHL_TYPE_READ:  s_next.frame = {1'b1, `PHL_TYPE_READ, head[11:8], 1'b0,
                                                 8'h00};
                `PHL_TYPE_WRITE: s_next.frame = {1'b1, `PHL_TYPE_WRITE, head[11:8],
                                                 head[7:0], 1'b0};
                default:         s_next.frame = {1'b1, head[14:12], `PHL_SPEED_100, 1'b0,
                                                 10'h000};
            endcase
            // Reserved types 110 and 111 are dropped rather than sent.
            if (head[14:13] == 2'h3) begin
                s_next.cnt = 5'h00;
            end
        end

        // One bit per accepted rising edge, top bit first; the stop bit leaves it low.
        if (rise && (s_reg.cnt != 5'h00)) begin
            s_next.link_service_request_line  = s_reg.frame[16];
            s_next.frame = {s_reg.frame[15:0], 1'b0};
            s_next.cnt   = s_reg.cnt - 5'h01;
        end

        // Request buffer: pop on load, then push a command write if room remains.
        if (load) begin
            s_next.bufm[0] = s_reg.bufm[1];
            s_next.buf_cnt = s_reg.buf_cnt - 2'h1;
        end
        slot = s_next.buf_cnt;
        if (WR && (ADDR == `PHL_REG_CMD) && (slot != 2'h2)) begin
            s_next.bufm[slot[0]] = WDATA[14:0];
            s_next.buf_cnt       = slot + 2'h1;
        end
        s_next.rdy = (s_next.buf_cnt != 2'h2);

        // Grant handling: the pairs are driven only after a grant, and we have no
        // packet to send, so the link releases with idle for one clock and lets go.
        if (rise) begin
            unique case (s_reg.own)
                OWN_PHY: begin
                    if (ctl_new == `PHL_CTL_GRANT) begin
                        s_next.own    = OWN_LINK;
                        s_next.ctl_o  = `PHL_CTL_IDLE;
                        s_next.ctl_oe = 1'b1;
                        s_next.d_o    = 2'h0;
                        s_next.d_oe   = 1'b1;
                        s_next.grants = s_reg.grants + 8'h01;
                    end
                end
                OWN_LINK: begin
                    s_next.own    = OWN_PHY;
                    s_next.ctl_oe = 1'b0;
                    s_next.d_oe   = 1'b0;
                end
            endcase
        end

        // Status transfer: first cycle of control 01 carries the speed, then pairs.
        if (rise && (s_reg.own == OWN_PHY)) begin
            if (ctl_new == `PHL_CTL_STATUS) begin
                if (!s_reg.st_act) begin
                    s_next.st_act = 1'b1;
                    s_next.st_cnt = 5'h00;
                end else if (s_reg.st_cnt != `PHL_ST_FULL) begin
                    s_next.st_sh  = {s_reg.st_sh[13:0], d_new};
                    s_next.st_cnt = s_reg.st_cnt + 5'h02;
                end
            end else if (s_reg.st_act) begin
                // An interrupted transfer is dropped; the phy sends it again.
                s_next.st_act = 1'b0;
                // Only a whole word or a 4-bit short word counts as a capture; a dropped partial must not
                // shield a software read from clearing the valid flag.
                if (s_reg.st_cnt == `PHL_ST_FULL) begin
                    cap              = 1'b1;
                    s_next.result    = s_reg.st_sh;
                    s_next.res_valid = 1'b1;
                    s_next.res_short = 1'b0;
                end else if (s_reg.st_cnt == `PHL_ST_SHORT) begin
                    cap              = 1'b1;
                    s_next.result    = {s_reg.st_sh[3:0], 12'h000};
                    s_next.res_valid = 1'b1;
                    s_next.res_short = 1'b1;
                end
            end
        end

        // Register writes and reads; a result read clears valid unless a new one lands.
        if (WR && (ADDR == `PHL_REG_CTRL)) begin
            s_next.enable = WDATA[0];
        end
        s_next.rdata = 32'h0000_0000;
        if (RD) begin
            unique case (ADDR)
                `PHL_REG_STAT:   s_next.rdata = {16'h0000, s_reg.grants, s_reg.ctl_acc,
                                                 s_reg.own == OWN_LINK, s_reg.cnt != 5'h00,
                                                 s_reg.buf_cnt == 2'h0, s_reg.buf_cnt == 2'h2,
                                                 2'h0};
                `PHL_REG_RESULT: s_next.rdata = {14'h0000, s_reg.res_short, s_reg.res_valid,
                                                 s_reg.result};
                `PHL_REG_CTRL:   s_next.rdata = {31'h0000_0000, s_reg.enable};
                default:         s_next.rdata = 32'h0000_0000;
            endcase
            if ((ADDR == `PHL_REG_RESULT) && !cap) begin
                s_next.res_valid = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    // Synchronous reset: every field takes a constant.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            s_reg        <= '0;
            s_reg.own    <= OWN_PHY;
            s_reg.enable <= `PHL_CTRL_RESET;
            s_reg.rdy    <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // Every output is a field of the state register.
    assign RDATA     = s_reg.rdata;
    assign REQ_READY = s_reg.rdy;
    assign LINK_SERVICE_REQUEST_LINE      = s_reg.link_service_request_line;
    assign CTL_O     = s_reg.ctl_o;
    assign CTL_OE    = s_reg.ctl_oe;
    assign D_O       = s_reg.d_o;
    assign D_OE      = s_reg.d_oe;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);

    sequence seq_first_bit;
        rise && (s_reg.cnt != 5'h00) && (s_reg.cnt == s_reg.len);
    endsequence

    sequence seq_last_bit;
        rise && (s_reg.cnt == 5'h01);
    endsequence

    a_link_service_request_line_on_edge: assert property ($changed(LINK_SERVICE_REQUEST_LINE) |-> $past(rise))
        else $error("Request line changed without an interface clock edge.");
    a_start_bit_one: assert property (seq_first_bit |=> LINK_SERVICE_REQUEST_LINE)
        else $error("Request frame did not start with a one.");
    a_stop_bit_zero: assert property (seq_last_bit |=> !LINK_SERVICE_REQUEST_LINE ##1 !LINK_SERVICE_REQUEST_LINE)
        else $error("Request frame did not end with a zero.");
    a_frame_len_type: assert property (seq_first_bit |-> s_reg.len ==
        ((s_reg.ftype == 3'h4) ? 5'h09 : (s_reg.ftype == 3'h5) ? 5'h11 : 5'h07))
        else $error("Frame length does not match request type.");
    a_read_frame_code: assert property ((seq_first_bit and (s_reg.ftype == 3'h4)) |->
        (s_reg.frame[15:13] == 3'h4) && !s_reg.frame[8])
        else $error("Read frame has wrong type code or stop bit.");
    a_write_frame_code: assert property ((seq_first_bit and (s_reg.ftype == 3'h5)) |->
        (s_reg.frame[15:13] == 3'h5) && !s_reg.frame[0])
        else $error("Write frame has wrong type code or stop bit.");
    a_bus_speed_zero: assert property ((seq_first_bit and (s_reg.ftype[2] == 1'b0)) |->
        (s_reg.frame[12:10] == 3'h0))
        else $error("Bus request speed or stop bit not zero.");
    a_no_reserved_drive: assert property (CTL_OE |-> (CTL_O != 2'h3))
        else $error("Link drove the reserved control code.");
    a_drive_after_grant: assert property ($rose(CTL_OE) |-> (s_reg.ctl_acc == 2'h3)
        && D_OE && $past(rise))
        else $error("Link drove the pairs without a grant.");
    a_status_capture: assert property ((rise && s_reg.st_act && (s_reg.own == OWN_PHY)
        && (s_reg.st_cnt == 5'h10) && (s_reg.ctl_acc == 2'h1)
        && (s_next.ctl_acc != 2'h1)) |=> s_reg.res_valid
        && (s_reg.result == $past(s_reg.st_sh)))
        else $error("Completed status word was not captured.");

    // A read of the result clears valid; a capture in that same cycle wins.
    a_result_rd_clear: assert property ((RD && (ADDR == `PHL_REG_RESULT) && !cap)
        |=> !s_reg.res_valid)
        else $error("Result read did not clear the valid flag.");
    a_short_capture: assert property ((cap && (s_reg.st_cnt == `PHL_ST_SHORT)) |=>
        s_reg.res_valid && s_reg.res_short && (s_reg.result[11:0] == 12'h000))
        else $error("Short status word was not captured.");
    a_release_on_edge: assert property ($fell(CTL_OE) |-> $past(rise) && !D_OE)
        else $error("Link let go of the pairs off an interface clock edge.");
endmodule

`default_nettype wire

// [src/phl_regs.svh]
// Constants of the link-side request controller: register offsets, field positions,
// reset values, request codes, frame lengths and control-pair codes.
// Assumes inclusion by bare name from the package and the controller module.
`ifndef PHL_REGS_SVH
`define PHL_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses on the local register port)
// ----------------------------------------------------------------------------
`define PHL_REG_CMD     4'h0
`define PHL_REG_STAT    4'h4
`define PHL_REG_RESULT  4'h8
`define PHL_REG_CTRL    4'hC

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define PHL_CMD_DATA_LSB  0
`define PHL_CMD_ADDR_LSB  8
`define PHL_CMD_TYPE_LSB  12
`define PHL_RES_VALID_BIT 16
`define PHL_RES_SHORT_BIT 17
`define PHL_CTRL_RESET    1'h0

// ----------------------------------------------------------------------------
// Request type codes and serial frame lengths
// ----------------------------------------------------------------------------
`define PHL_TYPE_READ   3'h4
`define PHL_TYPE_WRITE  3'h5
`define PHL_SPEED_100   2'h0
`define PHL_LEN_BUS     5'h07
`define PHL_LEN_READ    5'h09
`define PHL_LEN_WRITE   5'h11
`define PHL_ST_FULL     5'h10
`define PHL_ST_SHORT    5'h04

// ----------------------------------------------------------------------------
// Control-pair codes
// ----------------------------------------------------------------------------
`define PHL_CTL_IDLE    2'h0
`define PHL_CTL_STATUS  2'h1
`define PHL_CTL_RECV    2'h2
`define PHL_CTL_GRANT   2'h3

`endif

// [src/phl_pkg.sv]
// Types of the link-side request controller: bus ownership state and the
// packed state record of the controller.
// Assumes phl_regs.svh is on the include path.
`default_nettype none
`include "phl_regs.svh"

package phl_pkg;
    // Who drives the control and data pairs.
    typedef enum logic [0:0] {OWN_PHY, OWN_LINK} phl_own_e;

    // One queued request: type, register address, write data.
    typedef logic [14:0] phl_entry_t;

    typedef struct packed {
        logic [2:0]      clk_sync;   // Interface clock synchroniser.
        logic [5:0]      ctl_sync;   // Control pair, three stages of two bits.
        logic [5:0]      d_sync;     // Data pair, three stages of two bits.
        logic            clk_acc;    // Accepted interface clock level.
        logic [1:0]      ctl_acc;
        logic [1:0]      d_acc;
        phl_entry_t [1:0] bufm;      // Two-entry request buffer.
        logic [1:0]      buf_cnt;
        logic [16:0]     frame;      // Request stream, first bit on top.
        logic [4:0]      cnt;        // Bits still to send.
        logic [4:0]      len;
        logic [2:0]      ftype;
        logic            link_service_request_line;
        phl_own_e        own;
        logic [1:0]      ctl_o;
        logic            ctl_oe;
        logic [1:0]      d_o;
        logic            d_oe;
        logic            st_act;
        logic [4:0]      st_cnt;
        logic [15:0]     st_sh;
        logic [15:0]     result;
        logic            res_valid;
        logic            res_short;
        logic [7:0]      grants;
        logic            enable;
        logic            rdy;
        logic [31:0]     rdata;
    } phl_state_s;
endpackage

`default_nettype wire

// [test/phl_phy_model.sv]
// Behavioural phy for the request controller bench: makes the interface clock,
// decodes request frames, answers with status transfers, register loads and grants.
// Assumes the controller drives the two-way pairs only while it holds a grant.
`default_nettype none
module phl_phy_model #(
    parameter logic [3:0] STATUS_BITS = 4'hA
) (
    // Interface clock and request line
    output var  logic       IF_CLK,
    input  wire logic       LINK_SERVICE_REQUEST_LINE,
    // Link drive of the two-way pairs
    input  wire logic [1:0] CTL_O,
    input  wire logic       CTL_OE,
    input  wire logic [1:0] D_O,
    input  wire logic       D_OE,
    // Resolved wire levels and activity
    output var  logic [1:0] CTL_I,
    output var  logic [1:0] D_I,
    output var  logic       BUSY
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [16:0] frames[$];
    int          lens[$];
    logic [7:0]  regs[16];
    int          viol = 0;
    logic [16:0] rx;
    logic [15:0] st_word;
    int          n = 0, len = 17, st_left = 0, gnt = 0, st_top = 9;
    logic        rx_on = 1'b0, own = 1'b1, phy_oe = 1'b1;
    logic [1:0]  phy_ctl = 2'h0, phy_d = 2'h0, ctl_last = 2'h0, d_last = 2'h0;

    // Strap pins: power class and contender bit go into the self-ID packet. The
    // link-on tone would override the contender pin, but this bench never sends one.
    logic [2:0]  power_class_straps      = 3'h5;
    logic        external_clock_select   = 1'b1;
    logic        contender_or_linkon_pin = 1'b1;
    logic [3:0]  self_id_bits;
    assign self_id_bits = {power_class_straps, contender_or_linkon_pin};

    // Undriven pairs show the inverse of their last level so stale data never passes.
    assign CTL_I = CTL_OE ? CTL_O : (phy_oe ? phy_ctl : ~ctl_last);
    assign D_I   = D_OE ? D_O : (phy_oe ? phy_d : ~d_last);
    assign BUSY  = rx_on || (gnt != 0) || (st_left != 0);

    // Interface clock runs free, out of phase with the system clock.
    initial begin
        foreach (regs[i]) regs[i] = 8'h00;
        IF_CLK = 1'b0;
        #1.3;
        // The selected external source yields the same interface clock here.
        forever #12 IF_CLK = ~IF_CLK;
    end

    // Drive side first, so an action decoded at an edge starts at the next one.
    always @(posedge IF_CLK) begin
        ctl_last <= CTL_I;
        d_last   <= D_I;
        if ((CTL_OE === 1'b1) && (own || (CTL_O === 2'h3))) viol++;
        if (gnt == 1) begin
            phy_ctl <= #6 2'h3;
            own = 1'b0;
            gnt = 2;
        end else if (gnt == 2) begin
            phy_oe <= #6 1'b0;
            gnt = 3;
        end else if (gnt == 3) begin
            phy_oe  <= #6 1'b1;
            phy_ctl <= #6 2'h0;
            own = 1'b1;
            gnt = 0;
            // After each grant a short status follows, so the 4-bit path is used.
            st_word = {STATUS_BITS, 12'h000};
            st_top  = 3;
            st_left = 3;
        end else if (st_left > 0) begin
            phy_ctl <= #6 2'h1;
            phy_d   <= #6 (st_left == st_top) ? 2'h0 : st_word[15:14];
            if (st_left < st_top) st_word = st_word << 2;
            st_left--;
        end else begin
            phy_ctl <= #6 2'h0;
            phy_d   <= #6 2'h0;
        end
        // Frame receiver: length is known once the type bits are in.
        if (!rx_on) begin
            if (LINK_SERVICE_REQUEST_LINE === 1'b1) begin
                rx_on = 1'b1;
                rx = 17'h1;
                n = 1;
                len = 17;
            end
        end else begin
            rx = {rx[15:0], LINK_SERVICE_REQUEST_LINE};
            n++;
            if (n == 4) len = (rx[2:0] == 3'h4) ? 9 : ((rx[2:0] == 3'h5) ? 17 : 7);
            if (n == len) begin
                rx_on = 1'b0;
                frames.push_back(rx);
                lens.push_back(n);
                if (n == 9) begin
                    st_word = {STATUS_BITS, rx[4:1], regs[rx[4:1]]};
                    st_top  = 9;
                    st_left = 9;
                end else if (n == 17) begin
                    regs[rx[12:9]] = rx[8:1];
                end else if ((rx[5] == 1'b0) && (gnt == 0)) begin
                    gnt = 1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [test/tb.sv]
// Self-checking bench of the link-side request controller against the phy model.
// Assumes phl_regs.svh on the include path and the phy model compiled before.
`default_nettype none
`include "phl_regs.svh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [3:0] ST = 4'h6;
    logic        CLK_SYS = 1'b0, RST_N, WR, RD, LINK_SERVICE_REQUEST_LINE, CTL_OE, D_OE, REQ_READY, IF_CLK, BUSY;
    logic [3:0]  ADDR;
    logic [31:0] WDATA, RDATA, r;
    logic [1:0]  CTL_I, CTL_O, D_I, D_O;
    logic [7:0]  mirror[16], grants = 8'h00;
    logic [15:0] seed = 16'h0032;
    int          fails = 0, checks_done = 0, cyc = 0;

    phl_ctrl dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .REQ_READY(REQ_READY), .IF_CLK(IF_CLK), .LINK_SERVICE_REQUEST_LINE(LINK_SERVICE_REQUEST_LINE),
        .CTL_I(CTL_I), .CTL_O(CTL_O), .CTL_OE(CTL_OE), .D_I(D_I), .D_O(D_O), .D_OE(D_OE));
    phl_phy_model #(.STATUS_BITS(ST)) u_phy (.IF_CLK(IF_CLK), .LINK_SERVICE_REQUEST_LINE(LINK_SERVICE_REQUEST_LINE), .CTL_O(CTL_O),
        .CTL_OE(CTL_OE), .D_O(D_O), .D_OE(D_OE), .CTL_I(CTL_I), .D_I(D_I), .BUSY(BUSY));

    // System clock; the timeout guards against a hung handshake.
    always #2 CLK_SYS = ~CLK_SYS;
    always @(posedge CLK_SYS) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            report_and_stop();
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [16:0] exp_frame(input logic [2:0] t, input logic [3:0] a,
                                              input logic [7:0] d);
        if (t == `PHL_TYPE_READ) return {8'h0, 1'b1, t, a, 1'b0};
        if (t == `PHL_TYPE_WRITE) return {1'b1, t, a, d, 1'b0};
        return {10'h0, 1'b1, t, `PHL_SPEED_100, 1'b0};
    endfunction

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Bus cycles: strobe for one cycle, then one quiet cycle.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK_SYS);
        WR <= 1'b0;
        @(posedge CLK_SYS);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK_SYS);
        RD <= 1'b0;
        #1 d = RDATA;
        @(posedge CLK_SYS);
    endtask
    task automatic issue(input logic [2:0] t, input logic [3:0] a, input logic [7:0] d);
        wr(`PHL_REG_CMD, {17'h0, t, a, d});
    endtask

    // Wait for the frame and its effect at the phy, then compare both.
    task automatic verify(input logic [2:0] t, input logic [3:0] a, input logic [7:0] d);
        logic [16:0] f;
        logic [15:0] w;
        int k;
        f = 17'h0;
        k = 0;
        if (t > 3'h5) begin
            repeat (200) @(posedge CLK_SYS);
            chk("reserved frame count", u_phy.frames.size(), 0);
            return;
        end
        while ((u_phy.frames.size() == 0) && (k < 2000)) begin
            @(posedge CLK_SYS);
            k++;
        end
        if (u_phy.frames.size() > 0) f = u_phy.frames.pop_front();
        chk("frame", {15'h0, f}, {15'h0, exp_frame(t, a, d)});
        while (BUSY && (k < 4000)) begin
            @(posedge CLK_SYS);
            k++;
        end
        repeat (3) @(posedge IF_CLK);
        @(posedge CLK_SYS);
        if (t == `PHL_TYPE_READ) begin
            w = {ST, a, mirror[a]};
            rd(`PHL_REG_RESULT, r);
            chk("status word", r, {14'h0, 2'b01, w});
            rd(`PHL_REG_RESULT, r);
            chk("status cleared", r, {16'h0, w});
        end else if (t == `PHL_TYPE_WRITE) begin
            mirror[a] = d;
            chk("phy register", {24'h0, u_phy.regs[a]}, {24'h0, d});
        end else begin
            grants++;
            rd(`PHL_REG_STAT, r);
            chk("grant count", {24'h0, r[15:8]}, {24'h0, grants});
            chk("link released", {31'h0, r[5]}, 32'h0);
            rd(`PHL_REG_RESULT, r);
            chk("short status", r, {14'h0, 2'b11, ST, 12'h000});
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if ((fails == 0) && (checks_done > 0)) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Main sequence: reset state, buffer fill and drain, then every type and random mix.
    initial begin
        logic [2:0] t;
        foreach (mirror[i]) mirror[i] = 8'h00;
        RST_N = 1'b0;
        ADDR = 4'h0;
        WDATA = 32'h0;
        WR = 1'b0;
        RD = 1'b0;
        repeat (3) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        @(posedge CLK_SYS);
        #1 chk("pins after reset", {REQ_READY, LINK_SERVICE_REQUEST_LINE, CTL_OE, D_OE}, 4'h8);
        @(posedge CLK_SYS);
        rd(`PHL_REG_CTRL, r);
        chk("ctrl reset", r, 32'h0);
        rd(4'h2, r);
        chk("unmapped read", r, 32'h0);
        $display("test reset done");
        issue(3'h4, 4'h3, 8'h00);
        issue(3'h5, 4'h3, 8'h5A);
        #1 chk("buffer full ready", {31'h0, REQ_READY}, 32'h0);
        @(posedge CLK_SYS);
        issue(3'h3, 4'h0, 8'h00);
        rd(`PHL_REG_STAT, r);
        chk("stat full", {31'h0, r[2]}, 32'h1);
        wr(`PHL_REG_CTRL, 32'h1);
        verify(3'h4, 4'h3, 8'h00);
        verify(3'h5, 4'h3, 8'h5A);
        rd(`PHL_REG_STAT, r);
        chk("drained idle", {29'h0, r[4:2]}, 32'h2);
        $display("test buffer done");
        for (int i = 0; i < 20; i++) begin
            seed = lfsr(seed);
            t = (i < 8) ? i[2:0] : seed[2:0];
            issue(t, seed[11:8], seed[15:8]);
            verify(t, seed[11:8], seed[15:8]);
        end
        chk("phy saw no bus misuse", u_phy.viol, 0);
        chk("self id straps", {28'h0, u_phy.self_id_bits}, 32'hB);
        $display("test random done");
        report_and_stop();
    end
endmodule
`default_nettype wire
